//--- dv/dcsa_tlg_master.sv
// telegram source standing in for the serial bus master
`include "dcsa_regs.svh"
module dcsa_tlg_master
   import dcsa_pkg::*;
#(
   parameter int GAP = 12
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        send,
   input  wire logic [15:0] word,
   input  wire logic        keep,
   output logic             telegram_valid,
   output logic      [15:0] ctl_word
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] last_r;
   int          gap_cnt;
   // ----------------------------------------
   // telegrams on demand or as keep-alive
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         telegram_valid <= 1'h0;
         ctl_word       <= 16'hFFFF;
         last_r         <= `DCSA_CW_RST;
         gap_cnt        <= 0;
      end else if (send || (keep && gap_cnt >= GAP - 1)) begin
         telegram_valid <= 1'h1;
         ctl_word       <= send ? word : last_r;
         last_r         <= send ? word : last_r;
         gap_cnt        <= 0;
      end else begin
         // word released between telegrams: show no stale copy
         telegram_valid <= 1'h0;
         ctl_word       <= ~last_r;
         gap_cnt        <= gap_cnt + 1;
      end
   end
endmodule

//--- dv/drive_command_source_arbiter_bench.sv
// self-checking bench of the drive command source arbiter
`include "dcsa_regs.svh"
module drive_command_source_arbiter_bench
   import dcsa_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK  = 20;
   localparam int LIMIT = 6000;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, telegram_valid;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [15:0] ctl_word, word, fixed_speed, cw;
   logic        send, keep, din_brake_b, din_start, din_rev, er;
   logic [1:0]  din_setup, din_preset, preset, jog_sel, d, s, es, eb;
   logic        brake_req, start_req, reverse_req, freeze_freq, run_max, relay_on, trip, irq;
   logic [2:0]  setup_num;
   int          failures, checks_done, cyc;

   dcsa_top #(.TICK_CYCLES(TICK)) DUT (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .telegram_valid(telegram_valid), .ctl_word(ctl_word), .din_brake_b(din_brake_b),
      .din_start(din_start), .din_rev(din_rev), .din_setup(din_setup),
      .din_preset(din_preset), .brake_req(brake_req), .start_req(start_req),
      .reverse_req(reverse_req), .setup_num(setup_num),
      .preset_setpoint_source_choice(preset), .jog_sel(jog_sel),
      .fixed_speed(fixed_speed), .freeze_freq(freeze_freq), .run_max(run_max),
      .relay_on(relay_on), .trip(trip), .irq(irq));

   dcsa_tlg_master #(.GAP(12)) master (
      .clk(clk), .rst_b(rst_b), .send(send), .word(word), .keep(keep),
      .telegram_valid(telegram_valid), .ctl_word(ctl_word));

   // ----------------------------------------
   // clock, timeout and helpers
   // ----------------------------------------
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'h1;
      // wait for the answer; only the bench timeout ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   task automatic tlg(input logic [15:0] w);
      @(posedge clk);
      send <= 1'h1;
      word <= w;
      @(posedge clk);
      send <= 1'h0;
   endtask

   function automatic logic [1:0] cmb(input logic [1:0] m, input logic [1:0] x,
                                      input logic [1:0] y);
      case (m)
         2'h0: return x;
         2'h1: return y;
         2'h2: return x & y;
         default: return x | y;
      endcase
   endfunction

   function automatic logic [31:0] ctrl(input logic [1:0] m, input logic f,
                                        input logic [2:0] r);
      return {18'h0, r, f, {5{m}}};
   endfunction

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, send, keep, din_brake_b, din_start, din_rev} = 8'h04;
      {paddr, pwdata, word, din_setup, din_preset} = 84'h0;
      rst_b = 1'h0;
      repeat (3) @(posedge clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge clk);
      rchk("ctrl", `DCSA_A_CTRL, 32'h000007FF);
      rchk("tmo", `DCSA_A_TMO, 32'h00000001);
      rchk("jog1", `DCSA_A_JOG1, 32'h00000064);
      rchk("jog2", `DCSA_A_JOG2, 32'h00000064);
      apb(1'h0, 32'h00000020, 32'h0);
      chk("pslverr", 32'h1, 32'(er));
      chk("relay_on", 32'h1, 32'(relay_on));
      apb(1'h1, `DCSA_A_TMO, 32'h0);
      rchk("tmo", `DCSA_A_TMO, 32'h00000001);
      apb(1'h1, `DCSA_A_TMO, 32'h000000C8);
      rchk("tmo", `DCSA_A_TMO, 32'h00000063);
      apb(1'h1, `DCSA_A_TMO, 32'h1);
      keep <= 1'h1;
      for (int m = 0; m < 4; m++) begin
         apb(1'h1, `DCSA_A_CTRL, ctrl(m[1:0], 1'h1, 3'h0));
         for (int i = 0; i < 16; i++) begin
            d = i[1:0];
            s = i[3:2];
            din_brake_b <= d[0];
            din_start   <= d[0];
            din_rev     <= d[1];
            din_setup   <= d;
            din_preset  <= d;
            tlg({s[1], 1'h0, s, 5'h0, s[0], 3'h0, s[0], s});
            repeat (3) @(posedge clk);
            eb = cmb(m[1:0], ~d, ~s);
            es = cmb(m[1:0], d, s);
            chk("brake_req", 32'(eb[0]), 32'(brake_req));
            chk("start_req", 32'(es[0]), 32'(start_req));
            chk("reverse_req", 32'(es[1]), 32'(reverse_req));
            chk("setup_num", 32'({1'h0, es} + 3'h1), 32'(setup_num));
            chk("preset", 32'(es), 32'(preset));
         end
      end
      apb(1'h1, `DCSA_A_CTRL, ctrl(2'h1, 1'h0, 3'h0));
      apb(1'h1, `DCSA_A_JOG2, 32'h0000FFFF);
      rchk("jog2", `DCSA_A_JOG2, 32'h000001F4);
      din_preset <= 2'h2;
      tlg(16'h0205);
      repeat (3) @(posedge clk);
      chk("preset", 32'h2, 32'(preset));
      chk("jog_sel", 32'h2, 32'(jog_sel));
      chk("fixed_speed", 32'h1F4, 32'(fixed_speed));
      tlg(16'h0104);
      repeat (3) @(posedge clk);
      chk("fixed_speed", 32'h64, 32'(fixed_speed));
      apb(1'h1, `DCSA_A_CTRL, ctrl(2'h1, 1'h1, 3'h0));
      repeat (2) @(posedge clk);
      chk("jog_sel", 32'h0, 32'(jog_sel));
      apb(1'h1, `DCSA_A_FMAX, 32'h00000032);
      rchk("jog1", `DCSA_A_JOG1, 32'h00000032);
      din_start <= 1'h1;
      din_brake_b <= 1'h1;
      for (int r = 0; r < 6; r++) begin
         apb(1'h1, `DCSA_A_CTRL, ctrl(2'h3, 1'h1, r[2:0]));
         apb(1'h1, `DCSA_A_MASK, 32'(r == 0));
         // keep-alive stops only now, so no early loss during the writes
         keep <= 1'h0;
         tlg(16'h0004);
         repeat (TICK - 2) @(posedge clk);
         chk("relay_on", 32'h1, 32'(relay_on));
         repeat (TICK + 6) @(posedge clk);
         chk("relay_on", 32'(r == 0), 32'(relay_on));
         chk("freeze_freq", 32'(r == 1), 32'(freeze_freq));
         chk("start_req", 32'(r != 2 && r != 5), 32'(start_req));
         chk("jog_sel", 32'(r == 3), 32'(jog_sel));
         chk("run_max", 32'(r == 4), 32'(run_max));
         chk("trip", 32'(r == 5), 32'(trip));
         chk("irq", 32'(r == 0), 32'(irq));
         if (r == 0) begin
            rchk("stat", `DCSA_A_STAT, 32'h5);
            repeat (2) @(posedge clk);
            chk("irq", 32'h0, 32'(irq));
         end
         tlg(16'h0004);
         repeat (4) @(posedge clk);
         chk("relay_on", 32'(r != 5), 32'(relay_on));
         if (r == 5) begin
            apb(1'h1, `DCSA_A_STATE, 32'h1);
            tlg(16'h0004);
            repeat (4) @(posedge clk);
            chk("relay_on", 32'h1, 32'(relay_on));
            chk("trip", 32'h0, 32'(trip));
         end
      end
      stop_test();
   end
endmodule

//--- hdl/dcsa_pkg.sv
// types of the command source arbiter
package dcsa_pkg;
   typedef enum logic [1:0] {SRC_DIN, SRC_SER, SRC_AND, SRC_OR} dcsa_src_type;
   typedef enum logic [2:0] {RE_OFF, RE_FREEZE, RE_STOP, RE_JOG, RE_MAX, RE_TRIP,
                             RE_RSV6, RE_RSV7} dcsa_react_type;
   typedef struct packed {
      dcsa_src_type   src_brk;
      dcsa_src_type   src_sta;
      dcsa_src_type   src_rev;
      dcsa_src_type   src_set;
      dcsa_src_type   src_pre;
      logic           vendor_word_format;
      dcsa_react_type link_loss_reaction;
      logic [6:0]     tmo;
      logic [15:0]    bus_fixed_speed_one;
      logic [15:0]    bus_fixed_speed_two;
      logic [15:0]    fmax;
      logic [15:0]    cw;
      logic [25:0]    tick_cnt;
      logic [6:0]     sec_cnt;
      logic           lost;
      logic           trip;
      logic [2:0]     status;
      logic [2:0]     mask;
      logic           pready;
      logic           pslverr;
      logic [31:0]    prdata;
      logic           brake;
      logic           start;
      logic           rev;
      logic [2:0]     setup_num;
      logic [1:0]     preset_setpoint_source_choice;
      logic [1:0]     jog_sel;
      logic [15:0]    fixed_speed;
      logic           freeze;
      logic           run_max;
      logic           relay;
      logic           irq;
   } dcsa_state_type;
endpackage

//--- hdl/dcsa_regs.svh
// register map, field positions, reset values and timing counts
`ifndef DCSA_REGS_SVH
`define DCSA_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DCSA_A_CTRL   8'h00
`define DCSA_A_TMO    8'h04
`define DCSA_A_JOG1   8'h08
`define DCSA_A_JOG2   8'h0C
`define DCSA_A_FMAX   8'h10
`define DCSA_A_STAT   8'h14
`define DCSA_A_MASK   8'h18
`define DCSA_A_STATE  8'h1C
// ----------------------------------------
// control word bits, reset values and the timeout limit
// ----------------------------------------
`define DCSA_CW_PRE   0
`define DCSA_CW_BRK   2
`define DCSA_CW_STA   6
`define DCSA_CW_JOG   8
`define DCSA_CW_SET   12
`define DCSA_CW_REV   15
`define DCSA_CW_RST   16'h0004
`define DCSA_TMO_RST  7'h01
`define DCSA_TMO_MAX  7'h63
`define DCSA_JOG_RST  16'h0064
`define DCSA_FMAX_RST 16'h01F4
// ----------------------------------------
// timing
// ----------------------------------------
`define DCSA_CLK_HZ   40000000
`define DCSA_SEC_S    1
`define DCSA_TICK_W   26
`endif

//--- hdl/dcsa_top.sv
// drive command source arbiter with telegram supervision and APB registers
`include "dcsa_regs.svh"
module dcsa_top
   import dcsa_pkg::*;
#(
   parameter int TICK_CYCLES = `DCSA_CLK_HZ * `DCSA_SEC_S
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        telegram_valid,
   input  wire logic [15:0] ctl_word,
   input  wire logic        din_brake_b,
   input  wire logic        din_start,
   input  wire logic        din_rev,
   input  wire logic [1:0]  din_setup,
   input  wire logic [1:0]  din_preset,
   output logic             brake_req,
   output logic             start_req,
   output logic             reverse_req,
   output logic      [2:0]  setup_num,
   output logic      [1:0]  preset_setpoint_source_choice,
   output logic      [1:0]  jog_sel,
   output logic      [15:0] fixed_speed,
   output logic             freeze_freq,
   output logic             run_max,
   output logic             relay_on,
   output logic             trip,
   output logic             irq
);
   localparam logic [25:0] TICK_LAST = 26'(TICK_CYCLES - 1);

   dcsa_state_type s;
   dcsa_state_type n;
   logic           rst_meta_b;
   logic           rst_sync_b;
   logic           acc;
   logic           wr;
   logic           rd;
   logic           tick;
   logic [15:0]    cw;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic pick(dcsa_src_type m, logic d, logic b);
      case (m)
         SRC_DIN: pick = d;
         SRC_SER: pick = b;
         SRC_AND: pick = d & b;
         default: pick = d | b;
      endcase
   endfunction

   function automatic logic [15:0] clamp(logic [15:0] v, logic [15:0] m);
      clamp = (v > m) ? m : v;
   endfunction

   function automatic logic mapped(logic [31:0] a);
      mapped = (a[31:5] == 27'h0) && (a[1:0] == 2'h0);
   endfunction

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   assign acc  = psel & penable & s.pready;
   assign wr   = acc & pwrite & mapped(paddr);
   assign rd   = acc & ~pwrite;
   assign tick = s.tick_cnt == TICK_LAST;
   assign cw   = s.cw;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = s;
      // apb: answer one cycle into the access phase
      n.pready  = psel & penable & ~s.pready;
      n.pslverr = psel & penable & ~s.pready & ~mapped(paddr);
      n.prdata  = 32'h0;
      if (psel & penable & ~s.pready & ~pwrite & mapped(paddr)) begin
         case (paddr[7:0])
            `DCSA_A_CTRL:  n.prdata = {18'h0, s.link_loss_reaction, s.vendor_word_format,
                                       s.src_pre, s.src_set, s.src_rev, s.src_sta, s.src_brk};
            `DCSA_A_TMO:   n.prdata = {25'h0, s.tmo};
            `DCSA_A_JOG1:  n.prdata = {16'h0, s.bus_fixed_speed_one};
            `DCSA_A_JOG2:  n.prdata = {16'h0, s.bus_fixed_speed_two};
            `DCSA_A_FMAX:  n.prdata = {16'h0, s.fmax};
            `DCSA_A_STAT:  n.prdata = {29'h0, s.status};
            `DCSA_A_MASK:  n.prdata = {29'h0, s.mask};
            `DCSA_A_STATE: n.prdata = {16'h0, s.cw[15:4], s.relay, s.lost, s.trip, s.start};
            default:       n.prdata = 32'h0;
         endcase
      end
      if (wr) begin
         case (paddr[7:0])
            `DCSA_A_CTRL: begin
               n.src_brk            = dcsa_src_type'(pwdata[1:0]);
               n.src_sta            = dcsa_src_type'(pwdata[3:2]);
               n.src_rev            = dcsa_src_type'(pwdata[5:4]);
               n.src_set            = dcsa_src_type'(pwdata[7:6]);
               n.src_pre            = dcsa_src_type'(pwdata[9:8]);
               n.vendor_word_format = pwdata[10];
               n.link_loss_reaction = dcsa_react_type'(pwdata[13:11]);
            end
            `DCSA_A_TMO: begin
               // limit kept within 1 to 99 seconds
               if (pwdata[6:0] == 7'h0)
                  n.tmo = `DCSA_TMO_RST;
               else if (pwdata[31:7] != 25'h0 || pwdata[6:0] > `DCSA_TMO_MAX)
                  n.tmo = `DCSA_TMO_MAX;
               else
                  n.tmo = pwdata[6:0];
            end
            `DCSA_A_JOG1: n.bus_fixed_speed_one = clamp(pwdata[15:0], s.fmax);
            `DCSA_A_JOG2: n.bus_fixed_speed_two = clamp(pwdata[15:0], s.fmax);
            `DCSA_A_FMAX: begin
               n.fmax                = pwdata[15:0];
               n.bus_fixed_speed_one = clamp(s.bus_fixed_speed_one, pwdata[15:0]);
               n.bus_fixed_speed_two = clamp(s.bus_fixed_speed_two, pwdata[15:0]);
            end
            `DCSA_A_MASK:  n.mask = pwdata[2:0];
            `DCSA_A_STATE: if (pwdata[0]) n.trip = 1'b0;
            default: n.status = n.status;
         endcase
      end
      if (rd && paddr[7:0] == `DCSA_A_STAT && mapped(paddr))
         n.status = 3'h0;
      // telegram supervision
      if (telegram_valid) begin
         n.cw       = ctl_word;
         n.tick_cnt = 26'h0;
         n.sec_cnt  = 7'h0;
         n.status   = n.status | 3'h4;
         if (!n.trip)
            n.lost = 1'b0;
      end else begin
         n.tick_cnt = tick ? 26'h0 : 26'(s.tick_cnt + 26'h1);
         if (tick && s.sec_cnt != 7'h7F)
            n.sec_cnt = 7'(s.sec_cnt + 7'h1);
         // at or past the limit, so a lowered limit still ends the gap
         if (tick && 7'(s.sec_cnt + 7'h1) >= s.tmo && !s.lost) begin
            n.lost   = 1'b1;
            n.status = n.status | 3'h1;
            if (s.link_loss_reaction == RE_TRIP) begin
               n.trip   = 1'b1;
               n.status = n.status | 3'h2;
            end
         end
      end
      // command arbitration
      n.brake = pick(s.src_brk, ~din_brake_b, ~cw[`DCSA_CW_BRK]);
      n.start = pick(s.src_sta, din_start, cw[`DCSA_CW_STA]);
      if (s.trip || (s.lost && s.link_loss_reaction == RE_STOP))
         n.start = 1'b0;
      n.rev = pick(s.src_rev, din_rev, cw[`DCSA_CW_REV]);
      n.setup_num = 3'({pick(s.src_set, din_setup[1], cw[`DCSA_CW_SET + 1]),
                        pick(s.src_set, din_setup[0], cw[`DCSA_CW_SET])} + 3'h1);
      if (s.vendor_word_format)
         n.preset_setpoint_source_choice = {pick(s.src_pre, din_preset[1], cw[`DCSA_CW_PRE + 1]),
                                            pick(s.src_pre, din_preset[0], cw[`DCSA_CW_PRE])};
      else
         n.preset_setpoint_source_choice = din_preset;
      n.jog_sel = s.vendor_word_format ? 2'h0 : cw[`DCSA_CW_JOG +: 2];
      if (s.lost && s.link_loss_reaction == RE_JOG)
         n.jog_sel = 2'h1;
      n.fixed_speed = n.jog_sel[0] ? s.bus_fixed_speed_one :
                      n.jog_sel[1] ? s.bus_fixed_speed_two : 16'h0;
      n.freeze  = s.lost && s.link_loss_reaction == RE_FREEZE;
      n.run_max = s.lost && s.link_loss_reaction == RE_MAX;
      n.relay   = !(s.lost && s.link_loss_reaction != RE_OFF);
      n.irq     = |(n.status & n.mask);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s                     <= '0;
         s.src_brk             <= SRC_OR;
         s.src_sta             <= SRC_OR;
         s.src_rev             <= SRC_OR;
         s.src_set             <= SRC_OR;
         s.src_pre             <= SRC_OR;
         s.vendor_word_format  <= 1'b1;
         s.link_loss_reaction  <= RE_OFF;
         s.tmo                 <= `DCSA_TMO_RST;
         s.bus_fixed_speed_one <= `DCSA_JOG_RST;
         s.bus_fixed_speed_two <= `DCSA_JOG_RST;
         s.fmax                <= `DCSA_FMAX_RST;
         s.cw                  <= `DCSA_CW_RST;
         s.setup_num           <= 3'h1;
         s.relay               <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign prdata                        = s.prdata;
   assign pready                        = s.pready;
   assign pslverr                       = s.pslverr;
   assign brake_req                     = s.brake;
   assign start_req                     = s.start;
   assign reverse_req                   = s.rev;
   assign setup_num                     = s.setup_num;
   assign preset_setpoint_source_choice = s.preset_setpoint_source_choice;
   assign jog_sel                       = s.jog_sel;
   assign fixed_speed                   = s.fixed_speed;
   assign freeze_freq                   = s.freeze;
   assign run_max                       = s.run_max;
   assign relay_on                      = s.relay;
   assign trip                          = s.trip;
   assign irq                           = s.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_b);

   property p_brake_and;
      s.src_brk == SRC_AND && (din_brake_b || cw[`DCSA_CW_BRK]) |=> !brake_req;
   endproperty
   a_brake_and: assert property (p_brake_and) else $error("brake in AND mode");

   property p_start_or;
      s.src_sta == SRC_OR && din_start && !s.lost && !s.trip |=> start_req;
   endproperty
   a_start_or: assert property (p_start_or) else $error("start lost in OR mode");

   property p_rev_and;
      s.src_rev == SRC_AND && !(din_rev && cw[`DCSA_CW_REV]) |=> !reverse_req;
   endproperty
   a_rev_and: assert property (p_rev_and) else $error("reverse in AND mode");

   property p_setup_ser;
      s.src_set == SRC_SER |=> setup_num == 3'({1'b0, $past(cw[13:12])} + 3'h1);
   endproperty
   a_setup_ser: assert property (p_setup_ser) else $error("serial setup wrong");

   property p_setup_din;
      s.src_set == SRC_DIN |=> setup_num == 3'({1'b0, $past(din_setup)} + 3'h1);
   endproperty
   a_setup_din: assert property (p_setup_din) else $error("terminal setup wrong");

   property p_preset_gate;
      !s.vendor_word_format |=> preset_setpoint_source_choice == $past(din_preset);
   endproperty
   a_preset_gate: assert property (p_preset_gate) else $error("serial preset leaked");

   property p_jog_gate;
      s.vendor_word_format && !s.lost |=> jog_sel == 2'h0;
   endproperty
   a_jog_gate: assert property (p_jog_gate) else $error("jog in vendor format");

   property p_jog_clamp;
      s.bus_fixed_speed_one <= s.fmax && s.bus_fixed_speed_two <= s.fmax;
   endproperty
   a_jog_clamp: assert property (p_jog_clamp) else $error("jog above max");

   property p_relay;
      s.lost && s.link_loss_reaction != RE_OFF |=> !relay_on;
   endproperty
   a_relay: assert property (p_relay) else $error("relay kept on");

   property p_trip_hold;
      s.trip && telegram_valid && !wr |=> s.lost && trip;
   endproperty
   a_trip_hold: assert property (p_trip_hold) else $error("trip cleared by telegram");

   property p_trip_stop;
      s.trip |=> !start_req;
   endproperty
   a_trip_stop: assert property (p_trip_stop) else $error("start while tripped");

   property p_freeze;
      s.lost && s.link_loss_reaction == RE_FREEZE |=> freeze_freq;
   endproperty
   a_freeze: assert property (p_freeze) else $error("frequency not frozen");

   property p_pready;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_pready: assert property (p_pready) else $error("apb answer timing");

   c_timeout: cover property (s.status[0] ##1 !relay_on);
   c_trip:    cover property ($rose(trip));
   c_setup4:  cover property (setup_num == 3'h4);
   c_resume:  cover property (s.lost ##1 !s.lost);
   c_jogfb:   cover property (s.lost && jog_sel == 2'h1);
endmodule
